// ---- core/display_power_save_control.sv ----
// top of the display power save control block
module display_power_save_control #(
    parameter int LCD_W = pwr_save_pkg::LCD_WIDTH,
    parameter int GPIO_W = pwr_save_pkg::GPIO_WIDTH
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // register access port from the host interface
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic lut_access_i,
    // host display buffer access
    input wire pwr_save_pkg::buf_req_t buf_req_i,
    // display pipeline in
    input wire logic refresh_req_i,
    input wire logic [LCD_W-1:0] lcd_data_i,
    input wire logic panel_ctrl_i,
    input wire logic pwm_clk_i,
    input wire logic [GPIO_W-1:0] gpio_out_i,
    // register read back
    output logic [7:0] reg_rdata_o,
    output logic reg_ack_o,
    // display buffer side
    output logic buf_grant_o,
    output logic refresh_req_o,
    // panel side
    output logic [LCD_W-1:0] lcd_data_o,
    output logic panel_ctrl_o,
    output logic pwm_clock_out_o,
    output logic [GPIO_W-1:0] gpio_out_o,
    // usb and status
    output logic usb_clock_gate_o,
    output logic psave_o,
    output logic mc_down_o
);

    // ********************************************************
    // registered state
    // ********************************************************
    // every output except buf_grant_o and mc_down_o is one field of this word
    typedef struct packed {
        logic psave;
        logic usb_gate;
        logic [7:0] rdata;
        logic ack;
        logic refresh;
        logic [LCD_W-1:0] lcd;
        logic panel;
        logic pwm;
        logic [GPIO_W-1:0] gpio;
    } top_regs_t;

    top_regs_t state_reg;
    top_regs_t state_next;
    logic mc_grant;
    logic mc_down;
    logic ctrl_wr;
    logic usb_wr;
    logic ctrl_rd;
    logic usb_rd;
    logic panel_quiet;
    logic [LCD_W-1:0] lcd_gated;

    // reset image: power save set so nothing refreshes before software is ready,
    // and the panel outputs parked low
    localparam top_regs_t RESET_IMAGE = '{
        psave: pwr_save_pkg::PSAVE_EN_RESET,
        usb_gate: pwr_save_pkg::USB_GATE_RESET,
        rdata: 8'h00,
        ack: 1'b0,
        refresh: 1'b0,
        lcd: '0,
        panel: 1'b0,
        pwm: 1'b0,
        gpio: '0
    };

    // ********************************************************
    // address decode and readback helpers
    // ********************************************************
    // host addresses the power save control word
    function automatic logic hit_ctrl(input logic [15:0] addr);
        return addr == pwr_save_pkg::PWR_CTRL_OFFSET;
    endfunction

    // host addresses the usb control word
    function automatic logic hit_usb(input logic [15:0] addr);
        return addr == pwr_save_pkg::USB_CTRL_OFFSET;
    endfunction

    // control word image; undefined bits read as zero
    function automatic logic [7:0] ctrl_byte(input logic psave, input logic down);
        logic [7:0] b;
        b = 8'h00;
        b[pwr_save_pkg::PSAVE_EN_BIT] = psave;
        b[pwr_save_pkg::MC_STATUS_BIT] = down;
        return b;
    endfunction

    // usb control word image; only the clock gate is held here
    function automatic logic [7:0] usb_byte(input logic gate);
        logic [7:0] b;
        b = 8'h00;
        b[pwr_save_pkg::USB_GATE_BIT] = gate;
        return b;
    endfunction

    // decoded strobes, shared by the update and the readback paths
    assign ctrl_wr = reg_wr_i && hit_ctrl(reg_addr_i);
    assign usb_wr = reg_wr_i && hit_usb(reg_addr_i);
    assign ctrl_rd = reg_rd_i && hit_ctrl(reg_addr_i);
    assign usb_rd = reg_rd_i && hit_usb(reg_addr_i);

    // ********************************************************
    // lcd data gating
    // ********************************************************
    // one quiet flag for the whole panel path keeps every output in step
    assign panel_quiet = state_reg.psave;
    // every data line parks low on its own, so a narrow panel bus is covered too;
    // the cost is one gate per line instead of a shared mux
    for (genvar i = 0; i < LCD_W; i++) begin : g_lcd_gate
        assign lcd_gated[i] = lcd_data_i[i] & ~panel_quiet;
    end

    // ********************************************************
    // memory controller power
    // ********************************************************
    // the controller sees the registered bit, so it moves on the same edge
    // as the panel gating; host buffer requests go straight in and the
    // grant comes back registered
    mc_power_ctrl #(
        .WAKE_CYCLES(pwr_save_pkg::MC_WAKE_CYCLES)
    ) u_mc (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .psave_i(state_reg.psave),
        .req_i(buf_req_i),
        .grant_o(mc_grant),
        .mc_down_o(mc_down)
    );

    // ********************************************************
    // control word, gating and readback
    // ********************************************************
    always_comb begin
        state_next = state_reg;
        // psave and usb_gate hold unless a write below changes them; every other field is reloaded each cycle
        // control writes, accepted in any mode
        if (ctrl_wr) begin
            state_next.psave = reg_wdata_i[pwr_save_pkg::PSAVE_EN_BIT];
        end
        // the usb gate follows only its own word, never the power save bit
        if (usb_wr) begin
            state_next.usb_gate = reg_wdata_i[pwr_save_pkg::USB_GATE_BIT];
        end

        // every access is acknowledged next cycle whatever the mode
        state_next.ack = reg_rd_i || reg_wr_i || lut_access_i;
        // readback; the status bit is taken live from the controller
        state_next.rdata = 8'h00;
        if (ctrl_rd) begin
            state_next.rdata = ctrl_byte(state_reg.psave, mc_down);
        end
        if (usb_rd) begin
            state_next.rdata = usb_byte(state_reg.usb_gate);
        end

        // panel path is forced quiet while power save is set
        state_next.refresh = refresh_req_i && !panel_quiet;
        state_next.lcd = lcd_gated;
        state_next.panel = panel_ctrl_i && !panel_quiet;
        state_next.pwm = pwm_clk_i && !panel_quiet;

        // gpio is never gated so the host keeps control
        state_next.gpio = gpio_out_i;
    end

    // ********************************************************
    // state register
    // ********************************************************
    // reset lands in power save; refresh waits until software clears the bit
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= RESET_IMAGE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ********************************************************
    // outputs, all straight from flip-flops
    // ********************************************************
    // host side; grant and status are registered inside the controller
    assign reg_rdata_o = state_reg.rdata;
    assign reg_ack_o = state_reg.ack;
    assign buf_grant_o = mc_grant;
    // panel side
    assign refresh_req_o = state_reg.refresh;
    assign lcd_data_o = state_reg.lcd;
    assign panel_ctrl_o = state_reg.panel;
    assign pwm_clock_out_o = state_reg.pwm;
    assign gpio_out_o = state_reg.gpio;
    // usb and status
    assign usb_clock_gate_o = state_reg.usb_gate;
    assign psave_o = state_reg.psave;
    assign mc_down_o = mc_down;

endmodule

// ---- core/pwr_save_pkg.sv ----
// shared types and constants for the display power save control block
package pwr_save_pkg;

    // ********************************************************
    // register map of the power save and usb control words
    // ********************************************************
    localparam logic [15:0] PWR_CTRL_OFFSET = 16'h0014;
    localparam logic [15:0] USB_CTRL_OFFSET = 16'h4000;
    localparam int PSAVE_EN_BIT = 4;
    localparam int MC_STATUS_BIT = 6;
    localparam int USB_GATE_BIT = 7;
    localparam logic PSAVE_EN_RESET = 1'b1;
    localparam logic USB_GATE_RESET = 1'b0;

    // ********************************************************
    // timing and widths
    // ********************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int MC_WAKE_NS = 16;
    localparam int MC_WAKE_CYCLES = (MC_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LCD_WIDTH = 18;
    localparam int GPIO_WIDTH = 8;
    localparam int WAKE_CNT_W = 4;

    // host buffer access request
    typedef struct packed {
        logic valid;
        logic write;
    } buf_req_t;

    // memory controller power states
    typedef enum logic [1:0] {
        MC_OFF,
        MC_WAKING,
        MC_ON
    } mc_state_t;

endpackage

// ---- core/mc_power_ctrl.sv ----
// memory controller power gating with on-demand wake for host accesses
module mc_power_ctrl #(
    parameter int WAKE_CYCLES = pwr_save_pkg::MC_WAKE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic psave_i,
    input wire pwr_save_pkg::buf_req_t req_i,
    // status
    output logic grant_o,
    output logic mc_down_o
);

    typedef struct packed {
        pwr_save_pkg::mc_state_t st;
        logic [pwr_save_pkg::WAKE_CNT_W-1:0] cnt;
        logic grant;
        logic down;
    } mc_regs_t;

    mc_regs_t state_reg;
    mc_regs_t state_next;

    // last count of the wake wait, cut to the counter width on purpose
    localparam logic [pwr_save_pkg::WAKE_CNT_W-1:0] WAKE_CNT_LAST =
        pwr_save_pkg::WAKE_CNT_W'(WAKE_CYCLES - 1);

    // ********************************************************
    // wake on demand or when power save clears; once on, drop back whenever no request is pending while power save is set
    // ********************************************************
    always_comb begin
        state_next = state_reg;
        state_next.grant = 1'b0;
        case (state_reg.st)
            pwr_save_pkg::MC_OFF: begin
                if (!psave_i || req_i.valid) begin
                    state_next.st = pwr_save_pkg::MC_WAKING;
                    state_next.cnt = '0;
                end
            end
            pwr_save_pkg::MC_WAKING: begin
                state_next.down = 1'b0;
                if (state_reg.cnt == WAKE_CNT_LAST) begin
                    state_next.st = pwr_save_pkg::MC_ON;
                end else begin
                    state_next.cnt = state_reg.cnt + 1'b1;
                end
            end
            pwr_save_pkg::MC_ON: begin
                state_next.grant = req_i.valid;
                // powering down only between accesses avoids cutting one short
                if (psave_i && !req_i.valid) begin
                    state_next.st = pwr_save_pkg::MC_OFF;
                    state_next.down = 1'b1;
                end
            end
            default: begin
                state_next.st = pwr_save_pkg::MC_OFF;
                state_next.down = 1'b1;
            end
        endcase
    end

    // state register, powered down after reset
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= '{st: pwr_save_pkg::MC_OFF, cnt: '0, grant: 1'b0, down: 1'b1};
        end else begin
            state_reg <= state_next;
        end
    end

    assign grant_o = state_reg.grant;
    assign mc_down_o = state_reg.down;

endmodule

// ---- tb/dpsc_monitor.sv ----
// port assertions for the power save control block
module dpsc_monitor #(
    parameter int LCD_W = 18,
    parameter int GPIO_W = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // host side
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic lut_access_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire pwr_save_pkg::buf_req_t buf_req_i,
    // panel data in and out
    input wire logic [LCD_W-1:0] lcd_data_i,
    input wire logic [LCD_W-1:0] lcd_data_o,
    input wire logic [GPIO_W-1:0] gpio_out_i,
    input wire logic [GPIO_W-1:0] gpio_out_o,
    // status and gated outputs
    input wire logic reg_ack_o,
    input wire logic buf_grant_o,
    input wire logic refresh_req_o,
    input wire logic panel_ctrl_o,
    input wire logic pwm_clock_out_o,
    input wire logic usb_clock_gate_o,
    input wire logic psave_o,
    input wire logic mc_down_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // ****************
    // properties
    // ****************
    property p_enter; reg_wr_i && reg_addr_i == 16'h0014 |=> psave_o == $past(reg_wdata_i[4]);
    endproperty
    // both samples in power save, so either gating phase passes
    property p_gate; psave_o && $past(psave_o) |-> !refresh_req_o && !panel_ctrl_o
        && !pwm_clock_out_o && lcd_data_o == '0; endproperty
    property p_pass; !psave_o && !$past(psave_o) |-> lcd_data_o == $past(lcd_data_i);
    endproperty
    property p_down; (psave_o && !buf_req_i.valid) [*4] |-> mc_down_o; endproperty
    property p_grant; buf_req_i.valid |-> ##[0:6] buf_grant_o; endproperty
    property p_gpio; 1'b1 |=> gpio_out_o == $past(gpio_out_i); endproperty
    property p_usb; reg_wr_i && reg_addr_i == 16'h4000
        |=> usb_clock_gate_o == $past(reg_wdata_i[7]);
    endproperty
    property p_ack; reg_wr_i || reg_rd_i || lut_access_i |=> reg_ack_o; endproperty
    a_enter: assert property (p_enter) else $error("power save bit not taken");
    a_gate: assert property (p_gate) else $error("panel outputs live in power save");
    a_pass: assert property (p_pass) else $error("lcd data not passed");
    a_down: assert property (p_down) else $error("controller not down");
    a_grant: assert property (p_grant) else $error("buffer access not granted");
    a_gpio: assert property (p_gpio) else $error("gpio level lost");
    a_usb: assert property (p_usb) else $error("usb gate not taken");
    a_ack: assert property (p_ack) else $error("access not acked");
    c_grant: cover property (buf_grant_o && psave_o);
    c_leave: cover property ($fell(psave_o));
    c_usb: cover property ($rose(usb_clock_gate_o));
endmodule
bind display_power_save_control dpsc_monitor #(
    .LCD_W(LCD_W),
    .GPIO_W(GPIO_W)
) u_dpsc_monitor (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .lut_access_i(lut_access_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .buf_req_i(buf_req_i),
    .lcd_data_i(lcd_data_i),
    .lcd_data_o(lcd_data_o),
    .gpio_out_i(gpio_out_i),
    .gpio_out_o(gpio_out_o),
    .reg_ack_o(reg_ack_o),
    .buf_grant_o(buf_grant_o),
    .refresh_req_o(refresh_req_o),
    .panel_ctrl_o(panel_ctrl_o),
    .pwm_clock_out_o(pwm_clock_out_o),
    .usb_clock_gate_o(usb_clock_gate_o),
    .psave_o(psave_o),
    .mc_down_o(mc_down_o)
);

// ---- tb/buf_host.sv ----
// host model issuing display buffer requests
module buf_host (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic wr_i,
    input wire logic grant_i,
    output pwr_save_pkg::buf_req_t req_o,
    output logic done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_o = '0;
    initial done_o = 1'b0;
    // request held until grant, dropped at once to avoid a second grant
    always @(posedge go_i) begin
        @(negedge clk_i);
        req_o = '{1'b1, wr_i};
        do @(negedge clk_i); while (grant_i !== 1'b1);
        req_o = '0;
        done_o = ~done_o;
    end
endmodule

// ---- tb/display_power_save_control_tb.sv ----
// self-checking bench for the power save control block
module display_power_save_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, lut_access_i = 0;
    logic refresh_req_i = 0, panel_ctrl_i = 0, pwm_clk_i = 0, go = 0, wr = 0, done;
    logic [15:0] reg_addr_i = '0;
    logic [7:0] reg_wdata_i = '0, gpio_out_i = '0, reg_rdata_o, gpio_out_o;
    logic [17:0] lcd_data_i = '0, lcd_data_o;
    logic reg_ack_o, buf_grant_o, refresh_req_o, panel_ctrl_o, pwm_clock_out_o;
    logic usb_clock_gate_o, psave_o, mc_down_o;
    pwr_save_pkg::buf_req_t buf_req_i;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    display_power_save_control u_display_power_save_control (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rd_i(reg_rd_i),
        .lut_access_i(lut_access_i),
        .buf_req_i(buf_req_i),
        .refresh_req_i(refresh_req_i),
        .lcd_data_i(lcd_data_i),
        .panel_ctrl_i(panel_ctrl_i),
        .pwm_clk_i(pwm_clk_i),
        .gpio_out_i(gpio_out_i),
        .reg_rdata_o(reg_rdata_o),
        .reg_ack_o(reg_ack_o),
        .buf_grant_o(buf_grant_o),
        .refresh_req_o(refresh_req_o),
        .lcd_data_o(lcd_data_o),
        .panel_ctrl_o(panel_ctrl_o),
        .pwm_clock_out_o(pwm_clock_out_o),
        .gpio_out_o(gpio_out_o),
        .usb_clock_gate_o(usb_clock_gate_o),
        .psave_o(psave_o),
        .mc_down_o(mc_down_o)
    );
    buf_host u_buf_host (.clk_i(ref_clk_i), .go_i(go), .wr_i(wr), .grant_i(buf_grant_o),
        .req_o(buf_req_i), .done_o(done));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one strobe cycle, ack due at the next falling edge
    task automatic acc(logic w, logic r, logic l, logic [15:0] a, logic [7:0] d);
        @(negedge ref_clk_i);
        {reg_wr_i, reg_rd_i, lut_access_i, reg_addr_i, reg_wdata_i} = {w, r, l, a, d};
        @(negedge ref_clk_i);
        {reg_wr_i, reg_rd_i, lut_access_i} = '0;
        check("ack", reg_ack_o, 1);
        if (r) check("rdata", reg_rdata_o, d);
    endtask
    task automatic bufx(logic w);
        logic d0;
        d0 = done;
        wr = w;
        go = 1;
        @(negedge ref_clk_i);
        go = 0;
        for (int i = 0; i < 12 && done == d0; i++) @(negedge ref_clk_i);
        check("buffer done", done, !d0);
    endtask
    task automatic t_psave();
        check("psave", psave_o, 1);
        acc(0, 1, 0, 16'h0014, 8'h50);
        {lcd_data_i, refresh_req_i, panel_ctrl_i, pwm_clk_i, gpio_out_i} = {18'h2a5a5, 3'h7, 8'h3c};
        repeat (2) @(negedge ref_clk_i);
        check("panel", {lcd_data_o, refresh_req_o, panel_ctrl_o, pwm_clock_out_o}, 0);
        check("gpio", gpio_out_o, 8'h3c);
        acc(0, 0, 1, 16'h0000, 8'h00);
        bufx(1);
        bufx(0);
        repeat (4) @(negedge ref_clk_i);
        check("mc down", mc_down_o, 1);
    endtask
    task automatic t_leave();
        acc(1, 0, 0, 16'h4000, 8'h80);
        acc(0, 1, 0, 16'h4000, 8'h80);
        acc(1, 0, 0, 16'h0014, 8'h00);
        repeat (4) @(negedge ref_clk_i);
        check("lcd", {lcd_data_o, refresh_req_o, panel_ctrl_o, pwm_clock_out_o},
            {18'h2a5a5, 3'h7});
        // a second pattern with the controls low shows the path is live, not stuck
        {lcd_data_i, refresh_req_i, panel_ctrl_i, pwm_clk_i} = {18'h15a5a, 3'h0};
        repeat (2) @(negedge ref_clk_i);
        check("lcd low", {lcd_data_o, refresh_req_o, panel_ctrl_o, pwm_clock_out_o},
            {18'h15a5a, 3'h0});
        acc(0, 1, 0, 16'h0014, 8'h00);
        acc(0, 1, 0, 16'h0100, 8'h00);
        bufx(1);
        acc(1, 0, 0, 16'h0014, 8'h10);
        repeat (4) @(negedge ref_clk_i);
        acc(0, 1, 0, 16'h0014, 8'h50);
        check("usb", usb_clock_gate_o, 1);
        acc(1, 0, 0, 16'h4000, 8'h00);
        check("usb off", usb_clock_gate_o, 0);
    endtask
    // cut a hang short well past the expected run length
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(negedge ref_clk_i);
        rst_n_i = 1;
        t_psave();
        t_leave();
        conclude();
    end
endmodule
